//--- hdl/phy_strap_config_latch.v
`timescale 1ns/1ps
`include "strap_latch_regs.vh"
module phy_strap_config_latch (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [2:0]  mgmt_addr_strap,
   input  wire [2:0]  mode_strap,
   input  wire        isolate_strap,
   input  wire        speed_strap,
   input  wire        duplex_strap,
   input  wire        autoneg_en_strap,
   input  wire        bcast_disable_strap,
   input  wire        nand_tree_n_strap,
   output wire        strap_pins_oe,
   input  wire [4:0]  frame_phy_addr,
   output wire        addr_match,
   output reg  [4:0]  mgmt_addr,
   output reg  [2:0]  if_mode,
   output reg         mode_reserved,
   output reg         bcast_disable,
   output reg         nand_tree_mode,
   output reg         isolate,
   output reg         op_speed_100,
   output reg         op_full_duplex
);

   // ----------------------------------------
   // Strap synchronisers and release detect
   // ----------------------------------------
   reg [13:0] strap_s1_q;
   reg [13:0] strap_s2_q;
   reg [1:0]  rel_cnt_q;
   reg        latched_q;
   reg        pins_out_q;
   wire [13:0] strap_raw = {mgmt_addr_strap, mode_strap, isolate_strap, speed_strap,
                            duplex_strap, autoneg_en_strap, bcast_disable_strap,
                            nand_tree_n_strap, 2'h0};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_s1_q <= 14'h0000;
         strap_s2_q <= 14'h0000;
      end else begin
         strap_s1_q <= strap_raw;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Wait for synchroniser to fill after release, then capture once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rel_cnt_q  <= 2'h0;
         latched_q  <= 1'b0;
         pins_out_q <= 1'b0;
      end else begin
         if (rel_cnt_q != `REQ_CMD_SETTLE)
            rel_cnt_q <= rel_cnt_q + 2'h1;
         if (rel_cnt_q == `REQ_CMD_SETTLE && !latched_q)
            latched_q <= 1'b1;
         pins_out_q <= latched_q;
      end
   end

   wire capture = (rel_cnt_q == `REQ_CMD_SETTLE) && !latched_q;

   // Pins stay inputs through reset and capture, drive once done
   assign strap_pins_oe = pins_out_q;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   localparam SEL_NONE   = 3'h0;
   localparam SEL_CTRL   = 3'h1;
   localparam SEL_ADV    = 3'h2;
   localparam SEL_STATUS = 3'h3;
   localparam SEL_ADDR   = 3'h4;

   reg        bc_speed_q;
   reg        bc_autoneg_q;
   reg        bc_isolate_q;
   reg        bc_duplex_q;
   reg [3:0]  adv_cap_q;

   // One decode shared by the write path and the read mux
   function [2:0] reg_sel;
      input [11:0] addr;
      begin
         case (addr)
            `OFS_BASIC_CTRL:   reg_sel = SEL_CTRL;
            `OFS_ADVERTISE:    reg_sel = SEL_ADV;
            `OFS_STRAP_STATUS: reg_sel = SEL_STATUS;
            `OFS_MGMT_ADDR:    reg_sel = SEL_ADDR;
            default:           reg_sel = SEL_NONE;
         endcase
      end
   endfunction

   // Speed strap low removes the 100 Mbps abilities
   function [3:0] adv_from_speed;
      input speed_hi;
      begin
         if (speed_hi) begin
            adv_from_speed = `RST_ADV_CAP;
         end else begin
            adv_from_speed = `ADV_CAP_10_ONLY;
         end
      end
   endfunction

   // Synchronised strap fields
   wire [2:0] s_addr    = strap_s2_q[13:11];
   wire [2:0] s_mode    = strap_s2_q[10:8];
   wire       s_isolate = strap_s2_q[7];
   wire       s_speed   = strap_s2_q[6];
   wire       s_duplex  = strap_s2_q[5];
   wire       s_autoneg = strap_s2_q[4];
   wire       s_bcast   = strap_s2_q[3];
   wire       s_nand_n  = strap_s2_q[2];

   // Writes before capture are dropped so straps always seed first
   wire       wr_en   = psel && penable && pwrite;
   wire [2:0] wr_sel  = reg_sel(paddr);
   wire       sw_wr   = wr_en && latched_q;
   wire       ctrl_wr = sw_wr && (wr_sel == SEL_CTRL);
   wire       adv_wr  = sw_wr && (wr_sel == SEL_ADV);

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   // Strap-only state, read-only to software
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mgmt_addr      <= `ADDR_DEFAULT;
         if_mode        <= `MODE_MII;
         mode_reserved  <= 1'b0;
         bcast_disable  <= 1'b0;
         nand_tree_mode <= 1'b0;
      end else if (capture) begin
         mgmt_addr      <= {2'h0, s_addr};
         if_mode        <= s_mode;
         mode_reserved  <= (s_mode != `MODE_MII) && (s_mode != `MODE_B2B);
         bcast_disable  <= s_bcast;
         nand_tree_mode <= !s_nand_n;
      end
   end

   // ----------------------------------------
   // Software-owned control bits
   // ----------------------------------------
   // Speed select, seeded by its strap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_speed_q <= `RST_BC_SPEED;
      end else if (capture) begin
         bc_speed_q <= s_speed;
      end else if (ctrl_wr) begin
         bc_speed_q <= pwdata[`BC_SPEED_BIT];
      end
   end

   // Autonegotiation enable, seeded by its strap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_autoneg_q <= `RST_BC_AUTONEG;
      end else if (capture) begin
         bc_autoneg_q <= s_autoneg;
      end else if (ctrl_wr) begin
         bc_autoneg_q <= pwdata[`BC_AUTONEG_BIT];
      end
   end

   // Isolate, seeded by its strap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_isolate_q <= `RST_BC_ISOLATE;
      end else if (capture) begin
         bc_isolate_q <= s_isolate;
      end else if (ctrl_wr) begin
         bc_isolate_q <= pwdata[`BC_ISOLATE_BIT];
      end
   end

   // Duplex, high means half duplex
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_duplex_q <= `RST_BC_DUPLEX;
      end else if (capture) begin
         bc_duplex_q <= s_duplex;
      end else if (ctrl_wr) begin
         bc_duplex_q <= pwdata[`BC_DUPLEX_BIT];
      end
   end

   // Advertised abilities, seeded by the speed strap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adv_cap_q <= `RST_ADV_CAP;
      end else if (capture) begin
         adv_cap_q <= adv_from_speed(s_speed);
      end else if (adv_wr) begin
         adv_cap_q <= pwdata[`ADV_100FD_BIT:`ADV_10HD_BIT];
      end
   end

   // ----------------------------------------
   // Operating mode resolution
   // ----------------------------------------
   // Best own ability: 100 full, 100 half, 10 full, 10 half
   function best_is_100;
      input [3:0] cap;
      begin
         best_is_100 = cap[3] | cap[2];
      end
   endfunction

   function best_is_full;
      input [3:0] cap;
      begin
         best_is_full = cap[3] | (!cap[2] & cap[1]);
      end
   endfunction

   // Duplex bit high means half duplex
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isolate        <= 1'b0;
         op_speed_100   <= 1'b1;
         op_full_duplex <= 1'b0;
      end else begin
         isolate <= bc_isolate_q;
         if (!bc_autoneg_q) begin
            op_speed_100   <= bc_speed_q;
            op_full_duplex <= !bc_duplex_q;
         end else begin
            op_speed_100   <= best_is_100(adv_cap_q);
            op_full_duplex <= best_is_full(adv_cap_q);
         end
      end
   end

   // ----------------------------------------
   // Management address match
   // ----------------------------------------
   assign addr_match = (frame_phy_addr == mgmt_addr) ||
                       (!bcast_disable && frame_phy_addr == 5'h00);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   reg [31:0] ctrl_word;
   reg [31:0] adv_word;
   reg [31:0] status_word;

   always @* begin
      ctrl_word                  = 32'h0000_0000;
      ctrl_word[`BC_SPEED_BIT]   = bc_speed_q;
      ctrl_word[`BC_AUTONEG_BIT] = bc_autoneg_q;
      ctrl_word[`BC_ISOLATE_BIT] = bc_isolate_q;
      ctrl_word[`BC_DUPLEX_BIT]  = bc_duplex_q;
      adv_word                   = 32'h0000_0000;
      adv_word[4:0]              = `ADV_SELECTOR;
      adv_word[`ADV_100FD_BIT:`ADV_10HD_BIT] = adv_cap_q;
      status_word                = 32'h0000_0000;
      status_word[2:0]           = if_mode;
      status_word[3]             = mode_reserved;
      status_word[4]             = bcast_disable;
      status_word[5]             = nand_tree_mode;
      status_word[6]             = latched_q;
      status_word[7]             = op_speed_100;
      status_word[8]             = op_full_duplex;
   end

   always @* begin
      case (reg_sel(paddr))
         SEL_CTRL: begin
            prdata = ctrl_word;
         end
         SEL_ADV: begin
            prdata = adv_word;
         end
         SEL_STATUS: begin
            prdata = status_word;
         end
         SEL_ADDR: begin
            prdata = {27'h0000000, mgmt_addr};
         end
         default: begin
            prdata = 32'h0000_0000;
         end
      endcase
   end

endmodule

//--- hdl/strap_latch_regs.vh
`ifndef STRAP_LATCH_REGS_VH
`define STRAP_LATCH_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_BASIC_CTRL   12'h000
`define OFS_ADVERTISE    12'h010
`define OFS_STRAP_STATUS 12'h020
`define OFS_MGMT_ADDR    12'h024
// ----------------------------------------
// Field positions, encodings and other constants
// ----------------------------------------
`define BC_DUPLEX_BIT    8
`define BC_ISOLATE_BIT   10
`define BC_AUTONEG_BIT   12
`define BC_SPEED_BIT     13
`define ADV_10HD_BIT     5
`define ADV_10FD_BIT     6
`define ADV_100HD_BIT    7
`define ADV_100FD_BIT    8
`define MODE_MII         3'h0
`define MODE_B2B         3'h6
`define ADDR_DEFAULT     5'h01
`define ADV_SELECTOR     5'h01
`define REQ_CMD_SETTLE   2'h2
// ----------------------------------------
// Reset values, and the ability set captured when the speed strap is low
// ----------------------------------------
`define RST_BC_SPEED     1'b1
`define RST_BC_AUTONEG   1'b1
`define RST_BC_ISOLATE   1'b0
`define RST_BC_DUPLEX    1'b1
`define RST_ADV_CAP      4'hF
`define ADV_CAP_10_ONLY  4'h3
`endif

//--- verification/phy_strap_config_latch_tb_top.sv
`timescale 1ns/1ps
module phy_strap_config_latch_tb_top;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, unstrapped = 0;
   logic [11:0] paddr = 12'h000, cfg = 12'h000, s;
   logic [31:0] pwdata = 32'h0, rd;
   logic [4:0]  frame_phy_addr = 5'h00;
   wire  [11:0] pins;
   wire  [31:0] prdata;
   wire         pready, pslverr, oe, match, iso, spd, fd;
   int          failures = 0, check_count = 0, cyc = 0;
   logic [12:0] row_in [8] = '{13'h1000, 13'h0062, 13'h0E91, 13'h0AFB, 13'h050D, 13'h0776, 13'h0D81, 13'h09FC};
   logic [8:0]  row_st [8] = '{9'h1C0, 9'h179, 9'h1CA, 9'h0DB, 9'h14C, 9'h1FD, 9'h146, 9'h1EF};
   phy_strap_config_latch uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mgmt_addr_strap(pins[11:9]), .mode_strap(pins[8:6]), .isolate_strap(pins[5]), .speed_strap(pins[4]),
      .duplex_strap(pins[3]), .autoneg_en_strap(pins[2]), .bcast_disable_strap(pins[1]),
      .nand_tree_n_strap(pins[0]), .strap_pins_oe(oe), .frame_phy_addr(frame_phy_addr), .addr_match(match),
      .mgmt_addr(), .if_mode(), .mode_reserved(), .bcast_disable(), .nand_tree_mode(), .isolate(iso),
      .op_speed_100(spd), .op_full_duplex(fd));
   strap_board_model board (.cfg(cfg), .unstrapped(unstrapped), .strap_pins_oe(oe), .pins(pins));
   always #12.5 pclk = ~pclk;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         stop_test;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         presetn <= 1'b0; unstrapped <= row_in[i][12]; cfg <= row_in[i][11:0]; frame_phy_addr <= 5'h00;
         repeat (20) @(posedge pclk);
         chk({31'h0, oe}, 32'h0);
         presetn <= 1'b1;
         repeat (6) @(posedge pclk);
         chk({31'h0, oe}, 32'h1);
         s = row_in[i][12] ? 12'h21D : row_in[i][11:0];
         apb(1'b0, 12'h020, 32'h0, rd);
         chk(rd, {23'h0, row_st[i]});
         apb(1'b0, 12'h024, 32'h0, rd);
         chk(rd, {29'h0, s[11:9]});
         apb(1'b0, 12'h000, 32'h0, rd);
         chk(rd, {18'h0, s[4], s[2], 1'b0, s[5], 1'b0, s[3], 8'h0});
         apb(1'b0, 12'h010, 32'h0, rd);
         chk(rd, {23'h0, s[4] ? 4'hF : 4'h3, 5'h01});
         chk({31'h0, iso}, {31'h0, s[5]});
         chk({31'h0, match}, {31'h0, !s[1] || s[11:9] == 3'h0});
         frame_phy_addr <= {2'b00, s[11:9]};
         repeat (2) @(posedge pclk);
         chk({31'h0, match}, 32'h1);
         $display("row %0d done", i);
      end
      apb(1'b1, 12'h000, 32'h0, rd);
      repeat (2) @(posedge pclk);
      chk({30'h0, spd, fd}, 32'h1);
      apb(1'b1, 12'h000, 32'h2500, rd);
      repeat (2) @(posedge pclk);
      chk({29'h0, spd, fd, iso}, 32'h5);
      apb(1'b0, 12'h000, 32'h0, rd);
      chk(rd, 32'h2500);
      apb(1'b1, 12'h010, 32'h40, rd);
      apb(1'b0, 12'h010, 32'h0, rd);
      chk(rd, 32'h41);
      apb(1'b1, 12'h000, 32'h1000, rd);
      repeat (2) @(posedge pclk);
      chk({30'h0, spd, fd}, 32'h1);
      apb(1'b1, 12'h030, 32'hFFFFFFFF, rd);
      apb(1'b0, 12'h030, 32'h0, rd);
      chk(rd, 32'h0);
      apb(1'b1, 12'h024, 32'h1F, rd);
      apb(1'b0, 12'h024, 32'h0, rd);
      chk(rd, 32'h4);
      chk({31'h0, pslverr}, 32'h0);
      $display("register tests done");
      stop_test;
   end
endmodule

//--- verification/strap_board_model.sv
`timescale 1ns/1ps
module strap_board_model (
   input  wire [11:0] cfg,
   input  wire        unstrapped,
   input  wire        strap_pins_oe,
   output wire [11:0] pins
);
   // Internal pulls win when no resistor is fitted
   wire [11:0] level = unstrapped ? 12'h21D : cfg;
   // Pins carry the output function afterwards, never the strap value
   assign pins = strap_pins_oe ? ~level : level;
endmodule

//--- verification/strap_latch_monitor.sv
`timescale 1ns/1ps
module strap_latch_monitor (
   input wire       pclk,
   input wire       presetn,
   input wire [4:0] frame_phy_addr,
   input wire       addr_match,
   input wire [4:0] mgmt_addr,
   input wire [2:0] if_mode,
   input wire       mode_reserved,
   input wire       bcast_disable,
   input wire       strap_pins_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ADDR_HOLD: assert property (strap_pins_oe |=> $stable(mgmt_addr)) else $error("addr moved");
   AST_ADDR_TOP: assert property (mgmt_addr[4:3] == 2'b00) else $error("addr top set");
   AST_OWN: assert property (frame_phy_addr == mgmt_addr |-> addr_match) else $error("own miss");
   AST_BCAST: assert property (frame_phy_addr == 5'h00 && !bcast_disable |-> addr_match)
      else $error("bcast miss");
   AST_UNIQUE: assert property (frame_phy_addr == 5'h00 && bcast_disable |-> addr_match == (mgmt_addr == 5'h00))
      else $error("zero wrong");
   AST_OTHER: assert property (frame_phy_addr != 5'h00 && frame_phy_addr != mgmt_addr |-> !addr_match)
      else $error("false match");
   AST_MODE: assert property (mode_reserved == (if_mode != 3'h0 && if_mode != 3'h6))
      else $error("mode flag");
   AST_OE: assert property (strap_pins_oe |=> strap_pins_oe) else $error("oe fell");
   AST_HOLD: assert property (strap_pins_oe |=> $stable({if_mode, bcast_disable})) else $error("resampled");
endmodule
bind phy_strap_config_latch strap_latch_monitor mon (.pclk(pclk), .presetn(presetn), .frame_phy_addr(frame_phy_addr),
   .addr_match(addr_match), .mgmt_addr(mgmt_addr), .if_mode(if_mode), .mode_reserved(mode_reserved),
   .bcast_disable(bcast_disable), .strap_pins_oe(strap_pins_oe));
